// >>> hw/dbgrs_top.sv
// Debug run status block: run control, match flags and end-of-run FIFO count,
// reached as an AHB-Lite slave.
// Assumes comparator, trigger and FIFO logic on hclk drive the event inputs
// directly, without synchronisers, and that this is the only slave on hready.
//
// Notes on behaviour
// - Status register is read-only; writes ignored.
// - Match A flag cleared at start, set on match.
// - Match B flag cleared at start, set on match.
// - Run flag mirrors control bit while enabled.
// - Writing arm while enabled starts a run.
// - Run ends on full or trigger per mode.
// - Writing arm or enable zero stops run.
// - Count cleared at start, holds words at end.
// - Count never decrements on FIFO reads.
// - Arm write sets flag; completion clears arm.
// - Trace select: one begin trace, zero end.
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "dbgrs_defines.svh"

module dbgrs_top
  import dbgrs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        match_a,
  input  wire logic        match_b,
  input  wire logic        trigger_event,
  input  wire logic        fifo_full,
  input  wire logic [3:0]  fifo_words,
  output logic             run_active,
  output logic             debug_module_enable,
  output logic             trace_begin,
  output logic             irq
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  dbgrs_phase_t                phase_q;
  dbgrs_phase_t                phase_d;
  logic [31:0]                 addr_q;
  logic                        write_q;
  logic                        accept;
  logic                        access_end;
  dbgrs_reg_t                  wr_reg;
  dbgrs_reg_t                  rd_reg;
  logic                        wr_ctrl;
  logic                        wr_cfg;
  logic                        wr_irq_stat;
  logic                        wr_irq_mask;
  logic                        enable_q;
  logic                        arm_q;
  logic                        arm_d;
  logic                        begin_q;
  logic                        new_enable;
  logic                        new_arm;
  logic                        run_start;
  logic                        manual_end;
  logic                        auto_end;
  logic                        run_end;
  logic                        flag_a_q;
  logic                        flag_b_q;
  logic [3:0]                  count_q;
  logic [3:0]                  count_cap;
  dbgrs_status_t               status;
  dbgrs_events_t               events;
  logic [`DBGRS_IRQ_WIDTH-1:0] irq_stat;
  logic [`DBGRS_IRQ_WIDTH-1:0] irq_mask;
  logic [31:0]                 rdata_d;
  logic [31:0]                 hrdata_q;
  logic                        hreadyout_q;
  logic                        hresp_q;
  logic                        run_active_q;
  logic                        enable_out_q;
  logic                        begin_out_q;

  // --------------------------------------------------------------------------
  // Bus phases
  // --------------------------------------------------------------------------
  // One wait state per transfer: the write lands and the read data is
  // captured in the same edge, so a read right after a write sees it.
  assign accept     = hsel && htrans[1] && hready;
  assign access_end = (phase_q == DBGRS_PH_ACCESS);

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      DBGRS_PH_IDLE: begin
        if (accept) begin
          phase_d = DBGRS_PH_ACCESS;
        end
      end
      DBGRS_PH_ACCESS: begin
        phase_d = DBGRS_PH_ANSWER;
      end
      DBGRS_PH_ANSWER: begin
        if (accept) begin
          phase_d = DBGRS_PH_ACCESS;
        end else begin
          phase_d = DBGRS_PH_IDLE;
        end
      end
      default: begin
        phase_d = DBGRS_PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= DBGRS_PH_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q  <= 32'h00000000;
      write_q <= 1'b0;
    end else if (accept) begin
      addr_q  <= haddr;
      write_q <= hwrite;
    end
  end

  // Ready drops for the access cycle and rises for the answer cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
    end else begin
      hreadyout_q <= (phase_d != DBGRS_PH_ACCESS);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------------
  assign wr_reg      = dbgrs_decode(addr_q);
  assign wr_ctrl     = access_end && write_q && (wr_reg == DBGRS_REG_CTRL);
  assign wr_cfg      = access_end && write_q && (wr_reg == DBGRS_REG_CFG);
  assign wr_irq_stat = access_end && write_q && (wr_reg == DBGRS_REG_IRQ_STAT);
  assign wr_irq_mask = access_end && write_q && (wr_reg == DBGRS_REG_IRQ_MASK);
  // The status offset gets no write strobe at all

  // --------------------------------------------------------------------------
  // Run control
  // --------------------------------------------------------------------------
  assign new_enable = hwdata[`DBGRS_CTRL_EN_BIT];
  // Arm only takes while the same write keeps the module enabled
  assign new_arm    = hwdata[`DBGRS_CTRL_ARM_BIT] && new_enable;

  assign run_start  = wr_ctrl && new_arm && !arm_q;
  assign manual_end = wr_ctrl && arm_q && !new_arm;
  // Begin trace ends on a full FIFO, end trace on the trigger
  assign auto_end   = arm_q && (begin_q ? fifo_full : trigger_event);
  assign run_end    = manual_end || auto_end;

  always_comb begin
    arm_d = arm_q;
    if (run_start) begin
      arm_d = 1'b1;
    end else if (run_end) begin
      arm_d = 1'b0;
    end else if (wr_ctrl) begin
      arm_d = new_arm;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_q <= `DBGRS_RST_ARM;
    end else begin
      arm_q <= arm_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_q <= `DBGRS_RST_EN;
    end else if (wr_ctrl) begin
      enable_q <= new_enable;
    end
  end

  // Mode is frozen while armed so a run cannot change type midway
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      begin_q <= `DBGRS_RST_BEGIN;
    end else if (wr_cfg && !arm_q) begin
      begin_q <= hwdata[`DBGRS_CFG_BEGIN_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Match flags; a match in the start cycle is lost, as arm_q is still low then
  // --------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_a_q <= 1'b0;
    end else if (arm_q && match_a) begin
      flag_a_q <= 1'b1;
    end else if (run_start) begin
      flag_a_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_b_q <= 1'b0;
    end else if (arm_q && match_b) begin
      flag_b_q <= 1'b1;
    end else if (run_start) begin
      flag_b_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // FIFO valid count
  // --------------------------------------------------------------------------
  // Clamp guards against a FIFO that reports beyond its depth
  assign count_cap = (fifo_words > `DBGRS_FIFO_DEPTH) ? `DBGRS_FIFO_DEPTH : fifo_words;

  // Cleared at run start, loaded at run end; FIFO reads never touch it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= `DBGRS_RST_COUNT;
    end else if (run_start) begin
      count_q <= `DBGRS_RST_COUNT;
    end else if (run_end) begin
      count_q <= count_cap;
    end
  end

  // --------------------------------------------------------------------------
  // Status image
  // --------------------------------------------------------------------------
  always_comb begin
    status                  = '0;
    status.match_a_flag     = flag_a_q;
    status.match_b_flag     = flag_b_q;
    status.run_active_flag  = enable_q && arm_q;
    status.unused_zero      = 1'b0;
    status.fifo_valid_count = count_q;
  end

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  assign events.run_end = run_end;
  assign events.match_a = arm_q && match_a && !flag_a_q;
  assign events.match_b = arm_q && match_b && !flag_b_q;

  dbgrs_irq u_irq (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .events    (events),
    .clr_wr    (wr_irq_stat),
    .clr_data  (hwdata[`DBGRS_IRQ_WIDTH-1:0]),
    .mask_wr   (wr_irq_mask),
    .mask_data (hwdata[`DBGRS_IRQ_WIDTH-1:0]),
    .status_q  (irq_stat),
    .mask_q    (irq_mask),
    .irq_q     (irq)
  );

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Control bits use next-state values so the answer reflects a run end in this cycle
  assign rd_reg = dbgrs_decode(addr_q);

  always_comb begin
    rdata_d = 32'h00000000;
    case (rd_reg)
      DBGRS_REG_CTRL: begin
        rdata_d[`DBGRS_CTRL_EN_BIT]  = wr_ctrl ? new_enable : enable_q;
        rdata_d[`DBGRS_CTRL_ARM_BIT] = arm_d;
      end
      DBGRS_REG_CFG: begin
        rdata_d[`DBGRS_CFG_BEGIN_BIT] = begin_q;
      end
      DBGRS_REG_STAT: begin
        rdata_d[7:0] = status;
      end
      DBGRS_REG_IRQ_STAT: begin
        rdata_d[`DBGRS_IRQ_WIDTH-1:0] = irq_stat;
      end
      DBGRS_REG_IRQ_MASK: begin
        rdata_d[`DBGRS_IRQ_WIDTH-1:0] = irq_mask;
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (access_end && !write_q) begin
      hrdata_q <= rdata_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs to the rest of the debug logic
  // --------------------------------------------------------------------------
  // Registered from next-state values, so run and enable track arm_q and enable_q; trace select lags begin_q one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_active_q <= 1'b0;
      enable_out_q <= 1'b0;
      begin_out_q  <= 1'b0;
    end else begin
      run_active_q <= arm_d;
      enable_out_q <= wr_ctrl ? new_enable : enable_q;
      begin_out_q  <= begin_q;
    end
  end

  assign hrdata              = hrdata_q;
  assign hreadyout           = hreadyout_q;
  assign hresp               = hresp_q;
  assign run_active          = run_active_q;
  assign debug_module_enable = enable_out_q;
  assign trace_begin         = begin_out_q;

endmodule // dbgrs_top

// >>> hw/dbgrs_defines.svh
// Offsets, bit positions, reset values and counts of the debug run status block.
// Included by the package and the design modules; definitions only.
`ifndef DBGRS_DEFINES_SVH
`define DBGRS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define DBGRS_OFS_CTRL       8'h00
`define DBGRS_OFS_CFG        8'h04
`define DBGRS_OFS_STAT       8'h08
`define DBGRS_OFS_IRQ_STAT   8'h0c
`define DBGRS_OFS_IRQ_MASK   8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DBGRS_CTRL_EN_BIT    7
`define DBGRS_CTRL_ARM_BIT   6
`define DBGRS_CFG_BEGIN_BIT  6
`define DBGRS_IRQ_RUN_END    0
`define DBGRS_IRQ_MATCH_A    1
`define DBGRS_IRQ_MATCH_B    2
`define DBGRS_IRQ_WIDTH      3

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define DBGRS_RST_EN         1'h0
`define DBGRS_RST_ARM        1'h0
`define DBGRS_RST_BEGIN      1'h0
`define DBGRS_RST_COUNT      4'h0
`define DBGRS_RST_IRQ        3'h0
`define DBGRS_FIFO_DEPTH     4'h8

`endif

// >>> hw/dbgrs_pkg.sv
// Types shared by the debug run status block.
// Assumes dbgrs_defines.svh is on the include path.
`include "dbgrs_defines.svh"

package dbgrs_pkg;

  // --------------------------------------------------------------------------
  // Status register layout, bit 7 down to bit 0
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       match_a_flag;
    logic       match_b_flag;
    logic       run_active_flag;
    logic       unused_zero;
    logic [3:0] fifo_valid_count;
  } dbgrs_status_t;

  // Events routed to the interrupt logic, bit 2 down to bit 0
  typedef struct packed {
    logic match_b;
    logic match_a;
    logic run_end;
  } dbgrs_events_t;

  typedef enum logic [2:0] {
    DBGRS_REG_CTRL,
    DBGRS_REG_CFG,
    DBGRS_REG_STAT,
    DBGRS_REG_IRQ_STAT,
    DBGRS_REG_IRQ_MASK,
    DBGRS_REG_NONE
  } dbgrs_reg_t;

  typedef enum logic [1:0] {
    DBGRS_PH_IDLE,
    DBGRS_PH_ACCESS,
    DBGRS_PH_ANSWER
  } dbgrs_phase_t;

  function automatic dbgrs_reg_t dbgrs_decode(input logic [31:0] addr);
    dbgrs_reg_t r;
    r = DBGRS_REG_NONE;
    if (addr[31:8] == 24'h000000) begin
      case (addr[7:0])
        `DBGRS_OFS_CTRL:     r = DBGRS_REG_CTRL;
        `DBGRS_OFS_CFG:      r = DBGRS_REG_CFG;
        `DBGRS_OFS_STAT:     r = DBGRS_REG_STAT;
        `DBGRS_OFS_IRQ_STAT: r = DBGRS_REG_IRQ_STAT;
        `DBGRS_OFS_IRQ_MASK: r = DBGRS_REG_IRQ_MASK;
        default:             r = DBGRS_REG_NONE;
      endcase
    end
    return r;
  endfunction

endpackage

// >>> hw/dbgrs_irq.sv
// Sticky interrupt status with write-one-to-clear, mask and one level output.
// Assumes events are one-cycle pulses on hclk and writes come as strobes.
`timescale 1ns/100ps
`include "dbgrs_defines.svh"

module dbgrs_irq
  import dbgrs_pkg::*;
(
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire dbgrs_events_t               events,
  input  wire logic                        clr_wr,
  input  wire logic [`DBGRS_IRQ_WIDTH-1:0] clr_data,
  input  wire logic                        mask_wr,
  input  wire logic [`DBGRS_IRQ_WIDTH-1:0] mask_data,
  output logic      [`DBGRS_IRQ_WIDTH-1:0] status_q,
  output logic      [`DBGRS_IRQ_WIDTH-1:0] mask_q,
  output logic                             irq_q
);

  logic [`DBGRS_IRQ_WIDTH-1:0] evt_vec;

  assign evt_vec = events;

  // --------------------------------------------------------------------------
  // Sticky bits; a new event beats a clear in the same cycle
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < `DBGRS_IRQ_WIDTH; i++) begin : g_stat
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        status_q[i] <= 1'b0;
      end else if (evt_vec[i]) begin
        status_q[i] <= 1'b1;
      end else if (clr_wr && clr_data[i]) begin
        status_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= `DBGRS_RST_IRQ;
    end else if (mask_wr) begin
      mask_q <= mask_data;
    end
  end

  // Registered, so the line follows the status by one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

endmodule // dbgrs_irq

// >>> tb/dbgrs_chk.sv
// Concurrent checks on the ports of the debug run status block.
// Assumes hready is tied to hreadyout and everything runs on hclk.
`timescale 1ns/100ps

module dbgrs_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        trigger_event,
  input wire logic        fifo_full,
  input wire logic        run_active,
  input wire logic        debug_module_enable,
  input wire logic        trace_begin
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // --------------------------------------------------------------------------
  // Bus steps
  // --------------------------------------------------------------------------
  sequence s_take(logic w, logic [7:0] a);
    hsel && htrans[1] && hready && hwrite == w && haddr == {24'h0, a};
  endsequence
  // Control write: address phase, then the enable and arm bits of the data
  sequence s_ctrl(logic [1:0] v);
    s_take(1'b1, 8'h00) ##1 hwdata[7:6] == v;
  endsequence

  AST_OKAY: assert property (!hresp)
    else $error("slave answered with an error");
  AST_WAIT: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("answer cycle count wrong");
  AST_START: assert property (
    s_ctrl(2'b11) |-> ##2 run_active && debug_module_enable)
    else $error("run did not start");
  AST_STOP_ARM: assert property (s_ctrl(2'b10) |-> ##2 !run_active)
    else $error("arm clear did not stop run");
  AST_STOP_EN: assert property (s_ctrl(2'b01) |-> ##2 !run_active)
    else $error("enable clear did not stop run");
  AST_EN_ARM: assert property (run_active |-> debug_module_enable)
    else $error("run active without enable");
  AST_END_FULL: assert property (
    run_active && trace_begin && fifo_full && hreadyout |-> ##2 !run_active)
    else $error("full fifo did not end begin trace");
  AST_END_TRIG: assert property (
    run_active && !trace_begin && trigger_event && hreadyout |-> ##2 !run_active)
    else $error("trigger did not end end trace");
  AST_ZERO_BITS: assert property (
    s_take(1'b0, 8'h08) |-> ##2 hrdata[31:8] == 24'h0 && !hrdata[4])
    else $error("status reserved bits not zero");
  AST_CFG_LOCK: assert property (
    run_active && $past(run_active) |-> $stable(trace_begin))
    else $error("trace select changed during run");
endmodule // dbgrs_chk

// >>> tb/dbgrs_fifo_model.sv
// Behavioural trace fifo feeding the block, and the host's own read tally.
// Assumes one-cycle push, pop, clear and load pulses on hclk.
`timescale 1ns/100ps

module dbgrs_fifo_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       push,
  input  wire logic       pop,
  input  wire logic       clear,
  input  wire logic       load,
  input  wire logic [3:0] end_count,
  output logic      [3:0] fifo_words,
  output logic            fifo_full,
  output logic      [3:0] words_left
);
  logic [3:0] fill_q;
  logic [3:0] left_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fill_q <= 4'h0;
    end else if (clear) begin
      fill_q <= 4'h0;
    end else if (push && fill_q != 4'h8) begin
      fill_q <= fill_q + 4'h1;
    end else if (pop && fill_q != 4'h0) begin
      fill_q <= fill_q - 4'h1;
    end
  end

  // The block's count never moves on reads, so the host counts down itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left_q <= 4'h0;
    end else if (load) begin
      left_q <= end_count;
    end else if (pop && left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end
  end

  assign fifo_words = fill_q;
  assign fifo_full  = (fill_q == 4'h8);
  assign words_left = left_q;
endmodule // dbgrs_fifo_model

// >>> tb/dbgrs_top_tb_top.sv
// Self-checking bench of the debug run status block over AHB-Lite.
// Assumes the fifo model as far side; events are pulsed one cycle each.
`timescale 1ns/100ps

module dbgrs_top_tb_top;
  logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout, irq, fifo_full;
  logic        run_active, debug_module_enable, trace_begin;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  fifo_words, words_left, end_count;
  logic [6:0]  ev;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          mismatches, tests_run, exp_a, exp_b, exp_cnt, n, tb_v;

  dbgrs_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .match_a(ev[0]), .match_b(ev[1]), .trigger_event(ev[2]), .fifo_full(fifo_full),
    .fifo_words(fifo_words), .run_active(run_active),
    .debug_module_enable(debug_module_enable), .trace_begin(trace_begin), .irq(irq));

  dbgrs_fifo_model far_u (.hclk(hclk), .hresetn(hresetn), .push(ev[3]), .pop(ev[4]),
    .clear(ev[5]), .load(ev[6]), .end_count(end_count), .fifo_words(fifo_words),
    .fifo_full(fifo_full), .words_left(words_left));

  // --------------------------------------------------------------------------
  // Bus and checking tasks
  // --------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Entered just after a rising edge; returns at the edge that ends the data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge hclk);
    ev[i] <= 1'b0;
    @(posedge hclk);
  endtask

  task automatic stat(input logic run);
    xfer(1'b0, 32'h8, 32'h0);
    check("status", rd, {24'h0, exp_a[0], exp_b[0], run, 1'b0, exp_cnt[3:0]});
  endtask

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    give_verdict();
  end

  initial begin
    {hresetn, hsel, hwrite} = 3'b000;
    htrans = 2'b00;
    hsize = 3'h2;
    {haddr, hwdata} = 64'h0;
    ev = 7'h0;
    end_count = 4'h0;
    void'($urandom(32'hd401));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a < 24; a += 4) begin
      xfer(1'b0, a, 32'h0);
      check("reset value", rd, 32'h0);
    end
    xfer(1'b1, 32'h8, $urandom);
    xfer(1'b1, 32'h14, 32'hffffffff);
    xfer(1'b0, 32'h14, 32'h0);
    check("unmapped", rd, 32'h0);
    stat(1'b0);
    $display("test reset and access done");
    for (int m = 0; m < 4; m++) begin
      pulse(5);
      tb_v = (m == 0) ? 1 : (m == 1) ? 0 : $urandom % 2;
      n = (m < 2) ? 8 : $urandom % 8;
      xfer(1'b1, 32'h10, (m != 0));
      xfer(1'b1, 32'h4, tb_v << 6);
      xfer(1'b1, 32'h0, 32'hc0);
      {exp_a, exp_b, exp_cnt} = 0;
      stat(1'b1);
      // A mode change while armed must be ignored
      xfer(1'b1, 32'h4, (1 - tb_v) << 6);
      exp_a = $urandom % 2;
      exp_b = $urandom % 2;
      if (exp_a) pulse(0);
      if (exp_b) pulse(1);
      if (m == 1) repeat (8) pulse(3);
      if (m == 0) pulse(2);
      if (m >= 2) repeat (n) pulse(3);
      stat(1'b1);
      check("trace pin", trace_begin, tb_v);
      if (m == 0) repeat (8) pulse(3);
      if (m == 1) pulse(2);
      if (m >= 2) xfer(1'b1, 32'h0, (m == 2) ? 32'h80 : 32'h40);
      exp_cnt = n;
      stat(1'b0);
      check("run pin", run_active, 1'b0);
      check("enable pin", debug_module_enable, (m != 3));
      check("irq level", irq, (m != 0));
      end_count <= rd[3:0];
      pulse(6);
      repeat (3) pulse(4);
      stat(1'b0);
      check("host tally", words_left, (n > 3) ? n - 3 : 0);
      xfer(1'b0, 32'h0, 32'h0);
      check("control", rd, (m == 3) ? 32'h0 : 32'h80);
      xfer(1'b0, 32'hc, 32'h0);
      check("irq status", rd, {29'h0, exp_b[0], exp_a[0], 1'b1});
      xfer(1'b1, 32'hc, 32'h7);
      repeat (2) @(posedge hclk);
      check("irq cleared", irq, 1'b0);
      $display("test run mode %0d done", m);
    end
    give_verdict();
  end
endmodule // dbgrs_top_tb_top

bind dbgrs_top dbgrs_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trigger_event(trigger_event),
  .fifo_full(fifo_full), .run_active(run_active),
  .debug_module_enable(debug_module_enable), .trace_begin(trace_begin));
